// ### hw/gpc_port.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
module gpc_port
  import gpc_pkg::*;
#(
  parameter int PINS = 8,
  parameter bit HAS_RELOCATION = 1'b1,
  parameter bit HAS_INPUT_BUFFER_OFF = 1'b1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core data for plain gpio use
  input wire logic [7:0] core_out_val,
  input wire logic [7:0] core_out_en,
  // peripheral overrides
  input wire logic [3:0] tc0_cmp_out,
  input wire logic [3:0] tc0_cmp_en,
  input wire logic [1:0] tc1_cmp_out,
  input wire logic [1:0] tc1_cmp_en,
  input wire logic serial_en,
  input wire logic [3:0] serial_out,
  input wire logic [3:0] serial_oe,
  input wire logic spi_en,
  input wire logic [3:0] spi_out,
  input wire logic [3:0] spi_oe,
  // pads
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  output logic [7:0] pin_pulldown,
  output logic [7:0] pin_keeper,
  output logic [7:0] pin_slew_limit,
  output logic [7:0] pin_input_en,
  // to core
  output logic [7:0] pin_value,
  output logic [7:0] pin_event,
  output logic [1:0] irq0_priority,
  output logic [1:0] irq1_priority
);

  logic [7:0] irq0_source_bits_reg;
  logic [7:0] irq1_source_bits_reg;
  logic irq0_flag_reg;
  logic irq1_flag_reg;
  logic [3:0] irq_n_priority_reg;
  logic [5:0] relocation_reg;
  logic [7:0] cfg_reg [PINS];
  logic [7:0] in_reg;
  logic [7:0] in_prev_reg;
  logic [31:0] prdata_reg;

  logic [7:0] idx;
  logic idx_ok;
  logic wr_go;
  logic [7:0] wbyte;
  logic [7:0] sense_hit;
  logic [7:0] event_hit;
  logic [7:0] drv_val;
  logic [7:0] drv_en;
  logic [7:0] ibuf_on;

  function automatic logic mapped(input logic [7:0] i);
    mapped = (i == GPC_IDX_INPUT_VALUE) || (i == GPC_IDX_IRQ_PRIORITY) ||
             (i == GPC_IDX_IRQ_SOURCE_MASK_0) || (i == GPC_IDX_IRQ_SOURCE_MASK_1) ||
             (i == GPC_IDX_IRQ_FLAGS) || (i == GPC_IDX_PIN_RELOCATION) ||
             (i >= GPC_IDX_PIN_CONFIG_BASE && i <= GPC_IDX_PIN_CONFIG_LAST);
  endfunction

  function automatic logic [2:0] sense_of(input logic [7:0] c);
    sense_of = c[GPC_CFG_SENSE_MSB:GPC_CFG_SENSE_LSB];
  endfunction

  function automatic logic [2:0] drive_of(input logic [7:0] c);
    drive_of = c[GPC_CFG_DRIVE_MSB:GPC_CFG_DRIVE_LSB];
  endfunction

  // bus decode: word aligned, upper address bits must be clear
  assign idx = paddr[9:2];
  assign idx_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) && mapped(idx);
  assign wr_go = psel && penable && pwrite && idx_ok && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !idx_ok;
  assign prdata = prdata_reg;

  // read data is caught in the setup cycle so the access cycle is zero wait
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= 32'h0000_0000;
      if (idx_ok) begin
        unique case (1'b1)
          idx == GPC_IDX_INPUT_VALUE: prdata_reg[7:0] <= in_reg;
          idx == GPC_IDX_IRQ_PRIORITY: prdata_reg[3:0] <= irq_n_priority_reg;
          idx == GPC_IDX_IRQ_SOURCE_MASK_0: prdata_reg[7:0] <= irq0_source_bits_reg;
          idx == GPC_IDX_IRQ_SOURCE_MASK_1: prdata_reg[7:0] <= irq1_source_bits_reg;
          idx == GPC_IDX_IRQ_FLAGS: prdata_reg[1:0] <= {irq1_flag_reg, irq0_flag_reg};
          idx == GPC_IDX_PIN_RELOCATION: prdata_reg[5:0] <= relocation_reg;
          default: prdata_reg[7:0] <= cfg_reg[3'(idx - GPC_IDX_PIN_CONFIG_BASE)];
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq0_source_bits_reg <= GPC_RESET_VALUE;
      irq1_source_bits_reg <= GPC_RESET_VALUE;
      irq_n_priority_reg <= 4'h0;
    end else if (wr_go) begin
      if (idx == GPC_IDX_IRQ_SOURCE_MASK_0) begin
        irq0_source_bits_reg <= wbyte;
      end
      if (idx == GPC_IDX_IRQ_SOURCE_MASK_1) begin
        irq1_source_bits_reg <= wbyte;
      end
      if (idx == GPC_IDX_IRQ_PRIORITY) begin
        irq_n_priority_reg <= wbyte[3:0];
      end
    end
  end

  // without relocation hardware the register stays zero and reads zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      relocation_reg <= 6'h00;
    end else if (HAS_RELOCATION && wr_go && idx == GPC_IDX_PIN_RELOCATION) begin
      relocation_reg <= wbyte[5:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < PINS; i++) begin
        cfg_reg[i] <= GPC_RESET_VALUE;
      end
    end else if (wr_go && idx >= GPC_IDX_PIN_CONFIG_BASE) begin
      cfg_reg[3'(idx - GPC_IDX_PIN_CONFIG_BASE)] <= wbyte;
    end
  end

  // input path: invert, then gate by buffer enable
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      ibuf_on[i] = !(HAS_INPUT_BUFFER_OFF &&
                     sense_of(cfg_reg[i]) == GPC_SNS_INPUT_BUFFER_OFF);
    end
  end

  // a disabled buffer freezes the sampled value, so no edge can appear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      in_reg <= 8'h00;
      in_prev_reg <= 8'h00;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (ibuf_on[i]) begin
          in_reg[i] <= pin_in[i] ^ cfg_reg[i][GPC_CFG_INVERT_BIT];
        end
      end
      in_prev_reg <= in_reg;
    end
  end

  assign pin_value = in_reg;

  // one sense decode feeds both interrupt flags and events
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      sense_hit[i] = 1'b0;
      event_hit[i] = 1'b0;
      case (sense_of(cfg_reg[i]))
        GPC_SNS_BOTH: begin
          sense_hit[i] = in_reg[i] ^ in_prev_reg[i];
          event_hit[i] = sense_hit[i];
        end
        GPC_SNS_RISING: begin
          sense_hit[i] = in_reg[i] && !in_prev_reg[i];
          event_hit[i] = sense_hit[i];
        end
        GPC_SNS_FALLING: begin
          sense_hit[i] = !in_reg[i] && in_prev_reg[i];
          event_hit[i] = sense_hit[i];
        end
        GPC_SNS_LOW_LEVEL: begin
          sense_hit[i] = !in_reg[i];
          event_hit[i] = in_reg[i];
        end
        default: begin
          sense_hit[i] = 1'b0;
          event_hit[i] = 1'b0;
        end
      endcase
    end
  end

  assign pin_event = event_hit;

  // set beats a same-cycle write-one clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq0_flag_reg <= 1'b0;
      irq1_flag_reg <= 1'b0;
    end else begin
      if (|(sense_hit & irq0_source_bits_reg)) begin
        irq0_flag_reg <= 1'b1;
      end else if (wr_go && idx == GPC_IDX_IRQ_FLAGS && wbyte[0]) begin
        irq0_flag_reg <= 1'b0;
      end
      if (|(sense_hit & irq1_source_bits_reg)) begin
        irq1_flag_reg <= 1'b1;
      end else if (wr_go && idx == GPC_IDX_IRQ_FLAGS && wbyte[1]) begin
        irq1_flag_reg <= 1'b0;
      end
    end
  end

  // zero priority keeps the request off
  assign irq0_priority = irq0_flag_reg ? irq_n_priority_reg[GPC_PRIO0_LSB +: 2] : 2'h0;
  assign irq1_priority = irq1_flag_reg ? irq_n_priority_reg[GPC_PRIO1_LSB +: 2] : 2'h0;

  // output source selection, later overrides win
  always_comb begin
    drv_val = core_out_val;
    drv_en = core_out_en;
    // timer 1 owns pins 4-5 unless timer 0 moved a compare there
    for (int i = 0; i < 2; i++) begin
      if (tc1_cmp_en[i]) begin
        drv_val[i + 4] = tc1_cmp_out[i];
        drv_en[i + 4] = 1'b1;
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (tc0_cmp_en[i]) begin
        if (relocation_reg[GPC_RELOC_CMP_A_BIT + i]) begin
          // pwm sharing a pin with timer 1 is or-modulated
          drv_val[i + 4] = tc0_cmp_out[i] |
                           ((i < 2) && tc1_cmp_en[i[0]] && tc1_cmp_out[i[0]]);
          drv_en[i + 4] = 1'b1;
        end else begin
          drv_val[i] = tc0_cmp_out[i];
          drv_en[i] = 1'b1;
        end
      end
    end
    if (serial_en) begin
      for (int i = 0; i < 4; i++) begin
        if (relocation_reg[GPC_RELOC_SERIAL_BIT]) begin
          drv_val[i + 4] = serial_out[i];
          drv_en[i + 4] = serial_oe[i];
        end else begin
          drv_val[i] = serial_out[i];
          drv_en[i] = serial_oe[i];
        end
      end
    end
    if (spi_en) begin
      for (int i = 0; i < 4; i++) begin
        drv_val[i + 4] = spi_out[i];
        drv_en[i + 4] = spi_oe[i];
      end
      if (relocation_reg[GPC_RELOC_SPI_BIT]) begin
        drv_val[GPC_SPI_MOSI_PIN] = spi_out[GPC_SPI_SCK_PIN - 4];
        drv_en[GPC_SPI_MOSI_PIN] = spi_oe[GPC_SPI_SCK_PIN - 4];
        drv_val[GPC_SPI_SCK_PIN] = spi_out[GPC_SPI_MOSI_PIN - 4];
        drv_en[GPC_SPI_SCK_PIN] = spi_oe[GPC_SPI_MOSI_PIN - 4];
      end
    end
  end

  // pad controls come from flops so the pads never see decode glitches
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pin_pullup <= 8'h00;
      pin_pulldown <= 8'h00;
      pin_keeper <= 8'h00;
      pin_slew_limit <= 8'h00;
      pin_input_en <= 8'hFF;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        logic v;
        logic e;
        v = drv_val[i] ^ cfg_reg[i][GPC_CFG_INVERT_BIT];
        e = drv_en[i];
        pin_slew_limit[i] <= cfg_reg[i][GPC_CFG_SLEW_BIT];
        pin_input_en[i] <= ibuf_on[i];
        pin_out[i] <= v;
        pin_oe[i] <= e;
        pin_pullup[i] <= 1'b0;
        pin_pulldown[i] <= 1'b0;
        pin_keeper[i] <= 1'b0;
        unique case (drive_of(cfg_reg[i]))
          GPC_DRV_TOTEM: ;
          GPC_DRV_KEEPER: pin_keeper[i] <= 1'b1;
          GPC_DRV_PULLDOWN: pin_pulldown[i] <= !e;
          GPC_DRV_PULLUP: pin_pullup[i] <= !e;
          GPC_DRV_WIRED_OR: pin_oe[i] <= e && v;
          GPC_DRV_WIRED_AND: pin_oe[i] <= e && !v;
          GPC_DRV_WIRED_OR_PULL: begin
            pin_oe[i] <= e && v;
            pin_pulldown[i] <= 1'b1;
          end
          GPC_DRV_OPEN_DRAIN_WITH_PULLUP: begin
            pin_oe[i] <= e && !v;
            pin_pullup[i] <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // gpc_port

// ### include/gpc_pkg.sv
// What this block does
// - mask 0 bits choose interrupt 0 pins
// - mask 1 bits choose interrupt 1 pins
// - matching sense on chosen pin sets flag
// - write one clears flag, zero keeps
// - relocation works only on ports C-F
// - spi bit swaps clock and data-out pins
// - serial port bit moves to upper nibble
// - timer compare bits move pins 0-3 up
// - shared pin ORs both timer pwm outputs
// - config bit 7 enables slew limiter
// - config bit 6 inverts output and input
// - drive/pull field decoded into eight modes
// - sense field: both, rising, falling, low
// - level mode: events while pin high
// - sense 111 turns input buffer off
// - buffer-off only on ports A-F
// - sense governs interrupts and events alike, except low level: flags while low, events while high
// - level field enables irq, sets priority
package gpc_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] GPC_IDX_INPUT_VALUE = 8'h08;
  localparam logic [7:0] GPC_IDX_IRQ_PRIORITY = 8'h09;
  localparam logic [7:0] GPC_IDX_IRQ_SOURCE_MASK_0 = 8'h0A;
  localparam logic [7:0] GPC_IDX_IRQ_SOURCE_MASK_1 = 8'h0B;
  localparam logic [7:0] GPC_IDX_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] GPC_IDX_PIN_RELOCATION = 8'h0E;
  localparam logic [7:0] GPC_IDX_PIN_CONFIG_BASE = 8'h10;
  localparam logic [7:0] GPC_IDX_PIN_CONFIG_LAST = 8'h17;

  localparam logic [7:0] GPC_RESET_VALUE = 8'h00;
  localparam logic [7:0] GPC_FLAGS_USED = 8'h03;
  localparam logic [7:0] GPC_PRIORITY_USED = 8'h0F;
  localparam logic [7:0] GPC_RELOCATION_USED = 8'h3F;

  // per-pin configuration fields
  localparam int GPC_CFG_SLEW_BIT = 7;
  localparam int GPC_CFG_INVERT_BIT = 6;
  localparam int GPC_CFG_DRIVE_MSB = 5;
  localparam int GPC_CFG_DRIVE_LSB = 3;
  localparam int GPC_CFG_SENSE_MSB = 2;
  localparam int GPC_CFG_SENSE_LSB = 0;

  // relocation fields
  localparam int GPC_RELOC_SPI_BIT = 5;
  localparam int GPC_RELOC_SERIAL_BIT = 4;
  localparam int GPC_RELOC_CMP_D_BIT = 3;
  localparam int GPC_RELOC_CMP_C_BIT = 2;
  localparam int GPC_RELOC_CMP_B_BIT = 1;
  localparam int GPC_RELOC_CMP_A_BIT = 0;

  // spi pin order within the upper nibble: select, data out, data in, clock
  localparam int GPC_SPI_MOSI_PIN = 5;
  localparam int GPC_SPI_SCK_PIN = 7;

  // priority fields
  localparam int GPC_PRIO0_LSB = 0;
  localparam int GPC_PRIO1_LSB = 2;

  typedef enum logic [2:0] {
    GPC_DRV_TOTEM = 3'h0,
    GPC_DRV_KEEPER = 3'h1,
    GPC_DRV_PULLDOWN = 3'h2,
    GPC_DRV_PULLUP = 3'h3,
    GPC_DRV_WIRED_OR = 3'h4,
    GPC_DRV_WIRED_AND = 3'h5,
    GPC_DRV_WIRED_OR_PULL = 3'h6,
    GPC_DRV_OPEN_DRAIN_WITH_PULLUP = 3'h7
  } gpc_drive_t;

  typedef enum logic [2:0] {
    GPC_SNS_BOTH = 3'h0,
    GPC_SNS_RISING = 3'h1,
    GPC_SNS_FALLING = 3'h2,
    GPC_SNS_LOW_LEVEL = 3'h3,
    GPC_SNS_INPUT_BUFFER_OFF = 3'h7
  } gpc_sense_t;
endpackage

// ### test/gpc_pins_model.sv
`timescale 1ns/1ns
module gpc_pins_model (
  input wire logic ref_clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] pin_pulldown,
  input wire logic [7:0] pin_keeper,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  logic [7:0] last_q;
  always_ff @(posedge ref_clk) last_q <= pin_in;
  // a floating pad flips every cycle so a stale level never passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else if (pin_pulldown[i]) pin_in[i] = 1'b0;
      else if (pin_keeper[i]) pin_in[i] = last_q[i];
      else pin_in[i] = ~last_q[i];
    end
  end
endmodule // gpc_pins_model

// ### test/gpc_port_monitor.sv
`timescale 1ns/1ns
module gpc_port_monitor (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_keeper,
  input wire logic [7:0] pin_slew_limit,
  input wire logic [7:0] pin_input_en,
  input wire logic [7:0] pin_event,
  input wire logic [1:0] irq0_priority
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire wr = psel && penable && pwrite && pstrb[0];
  logic [7:0] cfg0_q;
  logic [7:0] lvl_q;
  logic q_ok;
  // low-level sense sets flags without events, so those pins are tracked apart
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg0_q <= 8'h00;
      lvl_q <= 8'h00;
      q_ok <= 1'b0;
    end else begin
      if (wr && paddr == 12'h040) cfg0_q <= pwdata[7:0];
      if (wr && paddr[11:5] == 7'h02) lvl_q[paddr[4:2]] <= (pwdata[2:0] == 3'h3);
      q_ok <= (lvl_q == 8'h00) && !(psel && pwrite);
    end
  end
  a_prio_cause: assert property ($rose(irq0_priority != 2'h0) && q_ok && lvl_q == 8'h00
    |-> $past(pin_event) != 8'h00) else $error("irq0 raised with no pin event");
  a_flag_clear: assert property (wr && paddr == 12'h030 && pwdata[1:0] == 2'h3
    && pin_event == 8'h00 && lvl_q == 8'h00 |=> irq0_priority == 2'h0)
    else $error("flag not cleared by write of one");
  a_prio_hold: assert property (irq0_priority != 2'h0 && !(psel && pwrite)
    |=> $stable(irq0_priority)) else $error("irq0 priority changed without a write");
  a_slew_follow: assert property (wr && paddr == 12'h040
    |-> ##[1:2] pin_slew_limit[0] == cfg0_q[7]) else $error("slew output wrong");
  a_buffer_off: assert property (wr && paddr == 12'h040
    |-> ##2 pin_input_en[0] == (cfg0_q[2:0] != 3'h7)) else $error("input enable wrong");
  a_keeper_mode: assert property (wr && paddr == 12'h040
    |-> ##2 (pin_oe[0] || pin_keeper[0] == (cfg0_q[5:3] == 3'h1))) else $error("keeper wrong");
  a_flags_reserved: assert property (psel && penable && !pwrite && paddr == 12'h030
    |-> prdata[31:2] == 30'h0) else $error("flag reserved bits not zero");
  a_reset_pins: assert property ($rose(nrst) |-> pin_input_en == 8'hFF)
    else $error("input buffers off after reset");
  cover property (wr && paddr == 12'h030);
  cover property ($rose(irq0_priority != 2'h0));
  cover property (psel && penable && pslverr);
endmodule // gpc_port_monitor
bind gpc_port gpc_port_monitor u_mon (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pslverr(pslverr), .pin_oe(pin_oe), .pin_keeper(pin_keeper),
  .pin_slew_limit(pin_slew_limit), .pin_input_en(pin_input_en), .pin_event(pin_event),
  .irq0_priority(irq0_priority));

// ### test/gpc_port_tb_top.sv
`timescale 1ns/1ns
module gpc_port_tb_top;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, ser_en, spi_en, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb, tc0_out, tc0_en, ser_out, ser_oe, spi_out, spi_oe;
  logic [1:0] tc1_out, tc1_en, irq0_priority, irq1_priority;
  logic [7:0] core_val, core_en, ext_val, ext_en, pin_in, pin_out, pin_oe, pin_pullup;
  logic [7:0] pin_pulldown, pin_keeper, pin_slew_limit, pin_input_en, pin_value, pin_event;
  logic [11:0] regs [6] = '{12'h024, 12'h028, 12'h02C, 12'h030, 12'h038, 12'h040};
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  gpc_port dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_out_val(core_val), .core_out_en(core_en),
    .tc0_cmp_out(tc0_out), .tc0_cmp_en(tc0_en), .tc1_cmp_out(tc1_out), .tc1_cmp_en(tc1_en),
    .serial_en(ser_en), .serial_out(ser_out), .serial_oe(ser_oe), .spi_en(spi_en),
    .spi_out(spi_out), .spi_oe(spi_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown), .pin_keeper(pin_keeper),
    .pin_slew_limit(pin_slew_limit), .pin_input_en(pin_input_en), .pin_value(pin_value),
    .pin_event(pin_event), .irq0_priority(irq0_priority), .irq1_priority(irq1_priority));
  gpc_pins_model u_pins (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown), .pin_keeper(pin_keeper),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // whole run is near 420 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e, m);
  endtask
  initial begin
    {psel, penable, pwrite, ser_en, spi_en, paddr, pwdata, nrst} = '0;
    {core_val, core_en, tc0_out, tc0_en, tc1_out, tc1_en, ser_out, ser_oe} = '0;
    {spi_out, spi_oe, ext_val} = '0;
    pstrb = 4'hF;
    ext_en = 8'hFF;
    wait_n(10);
    nrst <= 1'b1;
    wait_n(1);
    chk(pin_input_en, 8'hFF, "input enables at reset");
    chk(pready, 1'b1, "zero wait answer");
    foreach (regs[i]) rdchk(regs[i], 32'h0, "reset value");
    $display("test reset done");
    xfer(1'b1, 12'h02C, 32'h0000_00A5);
    rdchk(12'h02C, 32'h0000_00A5, "mask1 readback");
    xfer(1'b1, 12'h038, 32'h0000_003F);
    rdchk(12'h038, 32'h0000_003F, "relocation readback");
    xfer(1'b1, 12'h034, 32'h0000_00FF);
    chk(rerr, 1'b1, "unmapped write error");
    rdchk(12'h034, 32'h0, "unmapped read");
    $display("test access done");
    xfer(1'b1, 12'h024, 32'h0000_000E);
    xfer(1'b1, 12'h028, 32'h0000_0001);
    xfer(1'b1, 12'h02C, 32'h0000_0002);
    for (int m = 0; m < 8; m++) begin
      ext_val <= 8'h01;
      xfer(1'b1, 12'h040, m);
      wait_n(4);
      xfer(1'b1, 12'h030, 32'h0000_0003);
      wait_n(2);
      chk(irq0_priority, 2'h0, "flag after clear");
      chk(pin_event[0], m == 3, "level event while high");
      chk(pin_input_en[0], m != 7, "input buffer");
      ext_val <= 8'h00;
      wait_n(4);
      chk(irq0_priority, (m == 0 || m == 2 || m == 3) ? 2'h2 : 2'h0, "fall");
      xfer(1'b1, 12'h030, 32'h0000_0003);
      wait_n(4);
      chk(irq0_priority, (m == 3) ? 2'h2 : 2'h0, "level keeps setting");
      ext_val <= 8'h01;
      wait_n(4);
      chk(irq0_priority, (m < 2 || m == 3) ? 2'h2 : 2'h0, "rise");
    end
    xfer(1'b1, 12'h040, 32'h0);
    ext_val <= 8'h03;
    wait_n(4);
    chk(irq0_priority, 2'h0, "pin1 not in mask0");
    chk(irq1_priority, 2'h3, "pin1 in mask1");
    xfer(1'b1, 12'h030, 32'h0000_0001);
    chk(irq1_priority, 2'h3, "write zero keeps flag");
    xfer(1'b1, 12'h030, 32'h0000_0002);
    chk(irq1_priority, 2'h0, "write one clears flag");
    $display("test sense done");
    ext_en <= 8'hFE;
    for (int d = 0; d < 8; d++) begin
      xfer(1'b1, 12'h040, d << 3);
      wait_n(3);
      chk({pin_keeper[0], pin_pulldown[0], pin_pullup[0]},
        {d == 1, d == 2 || d == 6, d == 3 || d == 7}, "pull decode");
    end
    ext_en <= 8'hFF;
    xfer(1'b1, 12'h040, 32'h0000_0028);
    core_en <= 8'h01;
    core_val <= 8'h01;
    wait_n(3);
    chk(pin_oe[0], 1'b0, "wired and releases high");
    core_val <= 8'h00;
    wait_n(3);
    chk({pin_oe[0], pin_out[0]}, 2'b10, "wired and drives low");
    core_val <= 8'h01;
    xfer(1'b1, 12'h040, 32'h0000_0020);
    wait_n(3);
    chk({pin_oe[0], pin_out[0]}, 2'b11, "wired or drives high");
    xfer(1'b1, 12'h040, 32'h0000_00C0);
    wait_n(3);
    chk({pin_slew_limit[0], pin_out[0], pin_oe[0]}, 3'b101, "slew and invert out");
    core_en <= 8'h00;
    wait_n(3);
    chk(pin_value[0], 1'b0, "invert in");
    rdchk(12'h020, 32'h0000_0002, "input value read");
    xfer(1'b1, 12'h040, 32'h0);
    $display("test pin config done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 12'h038, 1 << i);
      tc0_en <= 4'h1 << i;
      tc0_out <= 4'h1 << i;
      wait_n(3);
      chk({pin_oe[i + 4], pin_out[i + 4], pin_oe[i]}, 3'b110, "timer0 moved");
    end
    xfer(1'b1, 12'h038, 32'h0000_0001);
    tc0_en <= 4'h1;
    tc1_en <= 2'h1;
    tc1_out <= 2'h1;
    tc0_out <= 4'h0;
    wait_n(3);
    chk(pin_out[4], 1'b1, "pwm or");
    tc1_out <= 2'h0;
    wait_n(3);
    chk(pin_out[4], 1'b0, "pwm or both low");
    {tc0_en, tc1_en} <= '0;
    xfer(1'b1, 12'h038, 32'h0000_0010);
    ser_en <= 1'b1;
    ser_out <= 4'hA;
    ser_oe <= 4'hF;
    wait_n(3);
    chk({pin_oe, pin_out[7:4]}, {8'hF0, 4'hA}, "serial moved up");
    ser_en <= 1'b0;
    spi_en <= 1'b1;
    spi_out <= 4'b0010;
    spi_oe <= 4'hF;
    xfer(1'b1, 12'h038, 32'h0);
    wait_n(3);
    chk(pin_out[7:4], 4'b0010, "spi unswapped");
    xfer(1'b1, 12'h038, 32'h0000_0020);
    wait_n(3);
    chk(pin_out[7:4], 4'b1000, "spi swapped");
    $display("test relocation done");
    finish_test();
  end
endmodule // gpc_port_tb_top
